//--- shared/hacc_pkg.sv
// shared constants, command codes, carrier types and helpers of the host audio command core
package hacc_pkg;
    // clock and rates, each figure in its own unit
    localparam int CLK_HZ = 10_000_000;
    localparam int SAMPLE_HZ = 8000;
    localparam int PWM_HZ = 256_000;
    localparam int DUR_UNIT_MS = 1;
    localparam int TICK_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int PWM_CYC = CLK_HZ / PWM_HZ;
    localparam int MS_CYC = CLK_HZ / 1000 * DUR_UNIT_MS;
    localparam logic [10:0] TICK_LAST = 11'(TICK_CYC - 1);
    localparam logic [5:0] PWM_LAST = 6'(PWM_CYC - 1);
    // command word layout
    localparam int WORD_W = 16;
    localparam int CMD_BUF_DEPTH = 2;
    localparam int AUD_FIFO_DEPTH = 8;
    localparam logic [4:0] BITS_SHORT = 5'h08;
    localparam logic [4:0] BITS_FULL = 5'h10;
    localparam int ARG_LSB = 4;
    localparam int TONE_ARG_LSB = 2;
    localparam logic [1:0] OP_TONE = 2'h3;
    localparam logic [3:0] OP_RESET = 4'h0;
    localparam logic [3:0] OP_STOP = 4'h1;
    localparam logic [3:0] OP_VOL = 4'h2;
    localparam logic [3:0] OP_DUR = 4'h4;
    localparam logic [3:0] OP_PCM = 4'h5;
    localparam logic [3:0] OP_ADPCM = 4'h6;
    // reset values
    localparam logic [11:0] DUR_RESET = 12'h000;
    localparam logic [3:0] VOL_RESET = 4'hF;
    // pitch index to phase step: 2^25 / (4.096 * 8000) = 2^10
    localparam int PHASE_SHIFT = 10;
    // volume: gain = level * 273 / 4096, close to level / 15
    localparam int VOL_MUL = 273;
    localparam logic [5:0] DUTY_OFS = 6'h03;
    localparam logic [6:0] ADPCM_IDX_MAX = 7'h58;
    localparam logic [14:0] ADPCM_STEP [89] = '{
        7, 8, 9, 10, 11, 12, 13, 14, 16, 17, 19, 21, 23, 25, 28, 31, 34, 37, 41, 45,
        50, 55, 60, 66, 73, 80, 88, 97, 107, 118, 130, 143, 157, 173, 190, 209, 230,
        253, 279, 307, 337, 371, 408, 449, 494, 544, 598, 658, 724, 796, 876, 963,
        1060, 1166, 1282, 1411, 1552, 1707, 1878, 2066, 2272, 2499, 2749, 3024, 3327,
        3660, 4026, 4428, 4871, 5358, 5894, 6484, 7132, 7845, 8630, 9493, 10442, 11487,
        12635, 13899, 15289, 16818, 18500, 20350, 22385, 24623, 27086, 29794, 32767};
    localparam logic signed [7:0] ADPCM_IDX_DELTA [8] = '{-1, -1, -1, -1, 2, 4, 6, 8};

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic full;
    } hacc_cmd_s;

    typedef enum logic [2:0] {
        KIND_BAD, KIND_RESET, KIND_STOP, KIND_VOL, KIND_DUR, KIND_TONE, KIND_PCM, KIND_ADPCM
    } hacc_kind_e;

    typedef enum logic [1:0] {ENG_IDLE, ENG_TONE, ENG_SAMPLE} hacc_eng_e;

    // opcode sits in the low bits; long commands need all 16 bits shifted in
    function automatic hacc_kind_e hacc_decode(input hacc_cmd_s c);
        hacc_kind_e k;
        k = KIND_BAD;
        if (c.word[1:0] == OP_TONE)
            k = c.full ? KIND_TONE : KIND_BAD;
        else
            case (c.word[3:0])
                OP_RESET: k = KIND_RESET;
                OP_STOP: k = KIND_STOP;
                OP_VOL: k = KIND_VOL;
                OP_DUR: k = c.full ? KIND_DUR : KIND_BAD;
                OP_PCM: k = c.full ? KIND_PCM : KIND_BAD;
                OP_ADPCM: k = KIND_ADPCM;
                default: k = KIND_BAD;
            endcase
        return k;
    endfunction
endpackage

//--- rtl/hacc_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides and a flush
`timescale 1ns/1ps
module hacc_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // depth must be a power of two so the extra pointer bit wraps cleanly
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_reg, rd_reg, level;
    logic push, pop;

    // full and empty come from the pointer distance
    assign level = wr_reg - rd_reg;
    assign in_ready = level != (AW + 1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data = mem_reg[rd_reg[AW-1:0]];
    assign push = in_valid & in_ready & ~flush;
    assign pop = out_valid & out_ready & ~flush;

    // storage is not reset; only the pointers need a defined state
    always_ff @(posedge clock)
    begin
        if (push)
            mem_reg[wr_reg[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= flush ? rd_reg : wr_reg + (AW + 1)'(push);
            rd_reg <= rd_reg + (AW + 1)'(pop);
        end
    end
endmodule

//--- rtl/hacc_sine_rom.sv
// sine lookup memory: quarter wave unfolded to a full cycle, registered read data
`timescale 1ns/1ps
module hacc_sine_rom (
    input wire logic clock,
    input wire logic rst,
    input wire logic [6:0] addr,
    output logic signed [11:0] sine_reg
);
    localparam logic [10:0] QUARTER [32] = '{
        50, 151, 251, 350, 449, 546, 642, 737, 830, 920, 1009, 1095, 1179, 1259, 1337, 1411,
        1483, 1550, 1614, 1674, 1729, 1781, 1828, 1871, 1910, 1944, 1973, 1997, 2017, 2032,
        2041, 2046};
    logic [4:0] quarter_idx;
    logic [10:0] magnitude;

    // second quarter of each half walks the table backwards, second half negates
    assign quarter_idx = addr[5] ? ~addr[4:0] : addr[4:0];
    assign magnitude = QUARTER[quarter_idx];

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sine_reg <= 12'h000;
        else
            sine_reg <= addr[6] ? -$signed({1'b0, magnitude}) : $signed({1'b0, magnitude});
    end
endmodule

//--- rtl/hacc_core.sv
// host audio command core: serial command port, command buffer, tone and sample playback
`timescale 1ns/1ps
module hacc_core
    import hacc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic host_clk,
    input wire logic host_cs_n,
    input wire logic host_serial_in,
    output logic rdy_n,
    output logic busy,
    output logic spk_p,
    output logic spk_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [2:0] sck_sync_reg, cs_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic sck_rise, cs_low, cs_rise, shift_en;
    logic [15:0] shift_reg, shift_next;
    logic [4:0] bits_reg, bits_next;
    hacc_cmd_s new_cmd, aud_out;
    hacc_cmd_s [1:0] cmd_buf_reg, buf_next;
    logic [1:0] buf_cnt_reg, cnt_next;
    hacc_kind_e head_kind, out_kind;
    logic head_valid, head_audio, buf_push, buf_pop, aud_in_ready, aud_out_valid;
    logic exec_reset, exec_stop, exec_vol, exec_dur, ctrl_flush;
    logic [3:0] vol_reg;
    logic [11:0] dur_reg, left_reg, left_next;
    hacc_eng_e eng_reg, eng_next;
    logic [10:0] tick_cnt_reg;
    logic [15:0] ms_cnt_reg, ms_next;
    logic tick, ms_wrap, tone_hold, tone_expire, fifo_take, aud_pop;
    logic pop_tone, pop_pcm, pop_adpcm, mute_reg, mute_next, finite_reg;
    logic [13:0] tone_idx;
    logic [23:0] inc_reg;
    logic [24:0] phase_reg, phase_next;
    logic signed [11:0] rom_q, tone_val, sample_sel, sample_reg, sample_next, vol_out;
    logic signed [15:0] pred_reg, adp_pred;
    logic [6:0] step_idx_reg, adp_idx;
    logic [3:0] nib;
    logic [14:0] step;
    logic [16:0] adp_diff;
    logic signed [17:0] adp_sum;
    logic signed [7:0] adp_idx_sum;
    logic signed [26:0] vol_gain, vol_prod;
    logic [5:0] pwm_cnt_reg, duty_reg;
    logic [11:0] dsm_u;
    logic signed [15:0] dsm_v, dsm_e, err1_reg, err2_reg;
    logic [4:0] dsm_q;
    logic frame;
    logic [10:0] idle_wait_reg;

    // host pins come from another clock domain: two flops before any use
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sck_sync_reg <= 3'h0;
            cs_sync_reg <= 3'h7;
            sdi_sync_reg <= 2'h0;
        end
        else
        begin
            sck_sync_reg <= {sck_sync_reg[1:0], host_clk};
            cs_sync_reg <= {cs_sync_reg[1:0], host_cs_n};
            sdi_sync_reg <= {sdi_sync_reg[0], host_serial_in};
        end
    end

    // edges seen on the synchronised copies; data has the same delay as the clock
    assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
    assign cs_low = ~cs_sync_reg[1];
    assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
    assign shift_en = cs_low & sck_rise;
    assign shift_next = shift_en ? {shift_reg[14:0], sdi_sync_reg[1]} : shift_reg;
    // older bits fall off the top, so the last 16 always remain
    assign bits_next = cs_rise ? 5'h00
        : (shift_en && bits_reg != BITS_FULL) ? bits_reg + 5'h01 : bits_reg;
    assign new_cmd = '{word: shift_reg, full: bits_reg == BITS_FULL};

    // command buffer: word of at least 8 bits latched on chip select rise when a slot is free
    assign buf_push = cs_rise && bits_reg >= BITS_SHORT
        && buf_cnt_reg != 2'(CMD_BUF_DEPTH);
    assign head_valid = buf_cnt_reg != 2'h0;
    assign head_kind = hacc_decode(cmd_buf_reg[0]);
    assign head_audio = head_kind inside {KIND_TONE, KIND_PCM, KIND_ADPCM};
    // a control word at the head never waits on the audio queue; audio waits for queue room
    assign buf_pop = head_valid & (~head_audio | aud_in_ready);
    assign exec_reset = buf_pop & (head_kind == KIND_RESET);
    assign exec_stop = buf_pop & (head_kind == KIND_STOP);
    assign exec_vol = buf_pop & (head_kind == KIND_VOL);
    assign exec_dur = buf_pop & (head_kind == KIND_DUR);
    assign ctrl_flush = exec_reset | exec_stop;

    always_comb
    begin
        buf_next = cmd_buf_reg;
        cnt_next = buf_cnt_reg;
        if (buf_pop)
        begin
            buf_next[0] = cmd_buf_reg[1];
            cnt_next = cnt_next - 2'h1;
        end
        if (buf_push)
        begin
            buf_next[cnt_next[0]] = new_cmd;
            cnt_next = cnt_next + 2'h1;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            shift_reg <= 16'h0000;
            bits_reg <= 5'h00;
            cmd_buf_reg <= '0;
            buf_cnt_reg <= 2'h0;
        end
        else
        begin
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            cmd_buf_reg <= buf_next;
            buf_cnt_reg <= cnt_next;
        end
    end

    // settings written by control commands
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            vol_reg <= VOL_RESET;
            dur_reg <= DUR_RESET;
        end
        else
        begin
            vol_reg <= exec_vol ? cmd_buf_reg[0].word[7:4] : vol_reg;
            // kept until replaced, so every later tone uses it
            dur_reg <= exec_reset ? DUR_RESET
                : exec_dur ? cmd_buf_reg[0].word[15:4] : dur_reg;
        end
    end

    // audio queue; when it fills, the buffer fills and ready drops
    hacc_fifo #(
        .WIDTH($bits(hacc_cmd_s)),
        .DEPTH(AUD_FIFO_DEPTH)
    ) u_aud_fifo (
        .clock(clock),
        .rst(rst),
        .flush(ctrl_flush),
        .in_valid(head_valid & head_audio),
        .in_ready(aud_in_ready),
        .in_data(cmd_buf_reg[0]),
        .out_valid(aud_out_valid),
        .out_ready(fifo_take),
        .out_data(aud_out)
    );

    hacc_sine_rom u_sine (
        .clock(clock),
        .rst(rst),
        .addr(phase_reg[24:18]),
        .sine_reg(rom_q)
    );

    // playback timing: one decision per 8 kHz tick
    assign tick = tick_cnt_reg == TICK_LAST;
    assign ms_wrap = ms_cnt_reg == 16'(MS_CYCLES - 1);
    assign tone_hold = (eng_reg == ENG_TONE) & finite_reg;
    assign tone_expire = tone_hold & ms_wrap & (left_reg == 12'h001);
    // a finite tone blocks the queue; an endless one yields to the next audio word
    assign fifo_take = tick & ~tone_hold & ~ctrl_flush;
    assign aud_pop = fifo_take & aud_out_valid;
    assign out_kind = hacc_decode(aud_out);
    assign pop_tone = aud_pop & (out_kind == KIND_TONE);
    assign pop_pcm = aud_pop & (out_kind == KIND_PCM);
    assign pop_adpcm = aud_pop & (out_kind == KIND_ADPCM);
    assign tone_idx = aud_out.word[15:TONE_ARG_LSB];

    always_comb
    begin
        eng_next = eng_reg;
        if (pop_tone)
            eng_next = ENG_TONE;
        else if (pop_pcm | pop_adpcm)
            eng_next = ENG_SAMPLE;
        else
        begin
            unique case (eng_reg)
                ENG_IDLE: eng_next = ENG_IDLE;
                ENG_SAMPLE: eng_next = tick ? ENG_IDLE : ENG_SAMPLE;
                ENG_TONE: eng_next = tone_expire ? ENG_IDLE : ENG_TONE;
            endcase
        end
        if (ctrl_flush)
            eng_next = ENG_IDLE;
    end

    // index zero keeps the previous step and mutes; any other audio un-mutes
    assign mute_next = pop_tone ? (tone_idx == 14'h0000)
        : (pop_pcm | pop_adpcm | ctrl_flush) ? 1'b0 : mute_reg;
    assign phase_next = (tick && eng_next == ENG_TONE)
        ? phase_reg + {1'b0, inc_reg} : phase_reg;
    assign left_next = pop_tone ? dur_reg
        : (tone_hold & ms_wrap) ? left_reg - 12'h001 : left_reg;
    assign ms_next = (pop_tone | ms_wrap | ~tone_hold) ? 16'h0000 : ms_cnt_reg + 16'h0001;

    // IMA ADPCM step: nibble scales the current step size
    assign nib = aud_out.word[7:4];
    assign step = ADPCM_STEP[step_idx_reg];
    assign adp_diff = 17'(step >> 3) + (nib[2] ? 17'(step) : 17'h00000)
        + (nib[1] ? 17'(step >> 1) : 17'h00000) + (nib[0] ? 17'(step >> 2) : 17'h00000);
    assign adp_sum = nib[3] ? 18'(pred_reg) - $signed({1'b0, adp_diff})
        : 18'(pred_reg) + $signed({1'b0, adp_diff});
    assign adp_pred = (adp_sum > 18'sh07FFF) ? 16'sh7FFF
        : (adp_sum < 18'sh38000) ? 16'sh8000 : adp_sum[15:0];
    assign adp_idx_sum = $signed({1'b0, step_idx_reg}) + ADPCM_IDX_DELTA[nib[2:0]];
    assign adp_idx = (adp_idx_sum < 0) ? 7'h00
        : (adp_idx_sum > $signed({1'b0, ADPCM_IDX_MAX})) ? ADPCM_IDX_MAX : adp_idx_sum[6:0];

    // sample for the modulator; idle or muted gives mid-scale, the DC average
    assign tone_val = mute_next ? 12'sh000 : rom_q;
    assign sample_sel = (eng_next == ENG_TONE) ? tone_val
        : pop_pcm ? $signed(aud_out.word[15:ARG_LSB])
        : pop_adpcm ? adp_pred[15:4] : 12'sh000;
    assign sample_next = (eng_next == ENG_IDLE) ? 12'sh000 : tick ? sample_sel : sample_reg;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            eng_reg <= ENG_IDLE;
            tick_cnt_reg <= 11'h000;
            ms_cnt_reg <= 16'h0000;
            left_reg <= 12'h000;
            finite_reg <= 1'b0;
            mute_reg <= 1'b0;
            inc_reg <= 24'h000000;
            phase_reg <= 25'h0000000;
            sample_reg <= 12'sh000;
            pred_reg <= 16'sh0000;
            step_idx_reg <= 7'h00;
        end
        else
        begin
            eng_reg <= eng_next;
            tick_cnt_reg <= tick ? 11'h000 : tick_cnt_reg + 11'h001;
            ms_cnt_reg <= ms_next;
            left_reg <= left_next;
            finite_reg <= pop_tone ? (dur_reg != 12'h000) : finite_reg;
            mute_reg <= mute_next;
            // step = index * 2^25 / (4.096 * 8000) per sample
            if (pop_tone && tone_idx != 14'h0000)
                inc_reg <= {tone_idx, PHASE_SHIFT'(0)};
            phase_reg <= phase_next;
            sample_reg <= sample_next;
            pred_reg <= ctrl_flush ? 16'sh0000 : pop_adpcm ? adp_pred : pred_reg;
            step_idx_reg <= ctrl_flush ? 7'h00 : pop_adpcm ? adp_idx : step_idx_reg;
        end
    end

    // volume: linear gain level/15; level zero only scales, switching carries on
    assign vol_gain = 27'(vol_reg * VOL_MUL);
    assign vol_prod = 27'(sample_reg) * vol_gain;
    assign vol_out = vol_prod[23:12];

    // second-order error feedback, noise transfer (1 - z^-1)^2, 32x oversampled
    assign frame = pwm_cnt_reg == 6'h00;
    assign dsm_u = {~vol_out[11], vol_out[10:0]};
    assign dsm_v = $signed({4'h0, dsm_u}) + (err1_reg <<< 1) - err2_reg;
    assign dsm_q = (dsm_v < 0) ? 5'h00 : (dsm_v > 16'sh0FFF) ? 5'h1F : dsm_v[11:7];
    assign dsm_e = dsm_v - $signed({4'h0, dsm_q, 7'h00});

    // pwm frame of 39 clocks gives 256 kHz switching
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pwm_cnt_reg <= 6'h00;
            duty_reg <= 6'h00;
            err1_reg <= 16'sh0000;
            err2_reg <= 16'sh0000;
            spk_p <= 1'b0;
            spk_n <= 1'b1;
            rdy_n <= 1'b1;
            busy <= 1'b0;
        end
        else
        begin
            pwm_cnt_reg <= (pwm_cnt_reg == PWM_LAST) ? 6'h00 : pwm_cnt_reg + 6'h01;
            if (frame)
            begin
                duty_reg <= 6'(dsm_q) + DUTY_OFS;
                err1_reg <= dsm_e;
                err2_reg <= err1_reg;
            end
            spk_p <= pwm_cnt_reg < duty_reg;
            spk_n <= pwm_cnt_reg >= duty_reg;
            // a word being shifted will take a slot, so ready drops during it
            rdy_n <= cs_low | (buf_cnt_reg == 2'(CMD_BUF_DEPTH));
            // an endless tone does not hold busy, so hosts pacing on busy can go on
            busy <= cs_low | head_valid | aud_out_valid
                | (eng_reg == ENG_SAMPLE) | tone_hold;
        end
    end

    // cycles that queued audio has waited on an idle engine; a stuck take shows as overrun
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            idle_wait_reg <= 11'h000;
        else
            idle_wait_reg <= (eng_reg == ENG_IDLE && aud_out_valid)
                ? idle_wait_reg + 11'h001 : 11'h000;
    end

    shift_msb_a: assert property (shift_en |=> shift_reg[0] == $past(sdi_sync_reg[1])
        && shift_reg[15:1] == $past(shift_reg[14:0])) else $error("serial shift wrong");
    latch_word_a: assert property (buf_push && !head_valid |=> head_valid
        && cmd_buf_reg[0].word == $past(shift_reg)) else $error("word not latched");
    ready_slot_a: assert property (!cs_low && buf_cnt_reg < 2'h2 ##1 !cs_low
        |-> !rdy_n) else $error("ready missing with free slot");
    ready_full_a: assert property (buf_cnt_reg == 2'h2 |=> rdy_n)
        else $error("ready while buffer full");
    busy_start_a: assert property ($rose(cs_low) |=> busy [*2])
        else $error("busy late at shift start");
    ctrl_now_a: assert property (head_valid && !head_audio && !buf_push
        |=> buf_cnt_reg == $past(buf_cnt_reg) - 2'h1) else $error("control delayed");
    dur_hold_a: assert property ($changed(dur_reg) |-> $past(exec_dur) || $past(exec_reset))
        else $error("duration changed on its own");
    tone_end_a: assert property (tone_expire && !ctrl_flush |=> eng_reg == ENG_IDLE
        && sample_reg == 12'sh000)
        else $error("tone did not end");
    queue_start_a: assert property (idle_wait_reg <= TICK_LAST + 11'h001)
        else $error("pending audio not started");
    mute_zero_a: assert property (pop_tone && tone_idx == 14'h0000 |=> mute_reg
        && sample_reg == 12'sh000 && inc_reg == $past(inc_reg))
        else $error("silent tone not muted");
    pwm_frame_a: assert property (frame |=> !frame [*8]) else $error("pwm frame short");
endmodule

//--- dv/hacc_host_model.sv
// host serial master model: shifts command words out msb first
`timescale 1ns/1ps
module hacc_host_model (
    input wire logic clock,
    output logic host_clk,
    output logic host_cs_n,
    output logic host_serial_in
);
    // link clock stands low between frames
    initial
    begin
        host_clk = 1'b0;
        host_cs_n = 1'b1;
        host_serial_in = 1'b0;
    end
    // 800 ns link clock; data changes only while the link clock is low
    task automatic send(input logic [31:0] w, input int n);
        host_cs_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = n - 1; i >= 0; i--)
        begin
            host_serial_in <= w[i];
            repeat (4) @(posedge clock);
            host_clk <= 1'b1;
            repeat (4) @(posedge clock);
            host_clk <= 1'b0;
        end
        repeat (4) @(posedge clock);
        host_cs_n <= 1'b1;
        // released data line shows the inverse so a stale bit cannot pass
        host_serial_in <= ~host_serial_in;
        repeat (4) @(posedge clock); // chip select high gap before the next word
    endtask
endmodule

//--- dv/hacc_core_tb.sv
// self-checking bench of the host audio command core
`timescale 1ns/1ps
module hacc_core_tb;
    import hacc_pkg::*;
    localparam int MS = 50;
    logic clock, rst, host_clk, host_cs_n, host_serial_in;
    logic rdy_n, busy, spk_p, spk_n;
    int num_errors = 0;
    int comparisons = 0;
    int n;
    hacc_core #(.MS_CYCLES(MS)) uut (.clock(clock), .rst(rst), .host_clk(host_clk),
        .host_cs_n(host_cs_n), .host_serial_in(host_serial_in), .rdy_n(rdy_n),
        .busy(busy), .spk_p(spk_p), .spk_n(spk_n));
    hacc_host_model host (.clock(clock), .host_clk(host_clk), .host_cs_n(host_cs_n),
        .host_serial_in(host_serial_in));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // waits for a free slot, then sends while checking the status outputs mid-frame
    task automatic cmd(input logic [31:0] w, input int nb);
        int k;
        k = 0;
        do
        begin
            @(negedge clock);
            k++;
        end while (rdy_n !== 1'b0 && k < 30000);
        check(rdy_n, 1'b0);
        @(posedge clock);
        fork
            host.send(w, nb);
            begin
                repeat (12) @(negedge clock);
                check(busy, 1'b1);
                check(rdy_n, 1'b1);
            end
        join
    endtask
    // counts cycles until busy drops, bounded so a stuck busy cannot hang the run
    task automatic busy_len(output int c);
        c = 0;
        @(negedge clock);
        while (busy !== 1'b0 && c < 30000)
        begin
            @(negedge clock);
            c++;
        end
    endtask
    // pwm frame rate and polarity with volume at zero; leading junk bits dropped
    task automatic t_volume();
        int r;
        logic prev;
        r = 0;
        cmd(32'h0A02, 12);
        busy_len(n);
        check(n <= 20, 1'b1);
        prev = spk_p;
        for (int i = 0; i < 390; i++)
        begin
            @(negedge clock);
            r += (spk_p === 1'b1 && prev === 1'b0) ? 1 : 0;
            prev = spk_p;
            check(spk_n, !spk_p);
        end
        check(r >= 9 && r <= 11, 1'b1);
        cmd({28'h000000F, OP_VOL}, 8);
    endtask
    // finite tones keep the duration; the silent one is paced on busy alone
    task automatic t_duration();
        cmd({16'hF, 12'd4, OP_DUR}, 20);
        cmd({16'h0, 14'd100, OP_TONE}, 16);
        busy_len(n);
        check(n >= 4 * MS - 10 && n <= 4 * MS + TICK_CYC + 10, 1'b1);
        @(posedge clock);
        host.send({16'h0, 14'd0, OP_TONE}, 16);
        busy_len(n);
        check(n >= 4 * MS - 10 && n <= 4 * MS + TICK_CYC + 10, 1'b1);
    endtask
    // stop acts at once on a long tone; reset restores the endless duration
    task automatic t_stop();
        cmd({16'h0, 12'hFFF, OP_DUR}, 16);
        cmd({16'h0, 14'd500, OP_TONE}, 16);
        cmd({24'h0, 4'h9, OP_STOP}, 8);
        busy_len(n);
        check(n <= 40, 1'b1);
        cmd({28'h0, OP_RESET}, 8);
        cmd({16'h0, 14'd500, OP_TONE}, 16);
        busy_len(n);
        check(n <= 1300, 1'b1);
        cmd({28'h0, OP_STOP}, 8);
    endtask
    // two nibbles are taken one per tick, each sample plays for one tick
    task automatic t_adpcm();
        cmd({24'h0, 4'h7, OP_ADPCM}, 8);
        cmd({24'h0, 4'hB, OP_ADPCM}, 8);
        busy_len(n);
        check(n >= TICK_CYC && n <= 3 * TICK_CYC + 4, 1'b1);
    endtask
    // pcm stream fills queue and buffer; ten words wait and the last one plays a tick
    task automatic t_fill();
        for (int i = 0; i < 14; i++)
            cmd({16'h0, 12'h100, OP_PCM}, 16);
        repeat (8) @(negedge clock);
        check(rdy_n, 1'b1);
        busy_len(n);
        check(n >= 10 * TICK_CYC && n <= 11 * TICK_CYC + 4, 1'b1);
    endtask
    // whole run is about 30000 clocks; give it some margin
    initial
    begin
        #5_000_000;
        num_errors++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        repeat (6) @(negedge clock);
        check({rdy_n, busy, spk_p, spk_n}, 4'h9);
        @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(negedge clock);
        check(rdy_n, 1'b0);
        t_volume();
        t_duration();
        t_stop();
        t_adpcm();
        t_fill();
        results();
    end
endmodule
